// ==== sim/mac_model.sv ====
// behavioural mac on the far side: sends nibbles, collects receive units
`timescale 1ns/1ps
module mac_model (
  input wire logic mac_clk_i,
  input wire logic link_ref_i,
  input wire logic rmii_i,
  input wire logic rx_dv_i,
  input wire logic [3:0] rxd_i,
  output logic tx_en_o,
  output logic [3:0] txd_o
);
  logic [3:0] rxq[$];
  initial
  begin
    tx_en_o = 1'h0;
    txd_o = 4'h0;
  end
  // mii only: no transmit clock exists in rmii mode
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge mac_clk_i);
      #1;
      tx_en_o = 1'h1;
      txd_o = 4'(i + 5);
    end
    @(negedge mac_clk_i);
    #1;
    tx_en_o = 1'h0;
    txd_o = ~txd_o;
  endtask
  // rmii: one dibit per reference period, changed on the falling reference edge
  task automatic send_ref(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge link_ref_i);
      tx_en_o = 1'h1;
      txd_o = 4'(i + 1);
    end
    @(negedge link_ref_i);
    tx_en_o = 1'h0;
  endtask
  always @(posedge mac_clk_i)
    if (!rmii_i && rx_dv_i === 1'h1) rxq.push_back(rxd_i);
  always @(posedge link_ref_i)
    if (rmii_i && rx_dv_i === 1'h1) rxq.push_back(rxd_i);
endmodule

// ==== sim/phy_mac_side_asserts.sv ====
// port-level checks for the mac-side block
`timescale 1ns/1ps
`include "phy_mac_params.svh"
module phy_mac_side_asserts (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic strap_rmii_i,
  input wire logic full_duplex_i,
  input wire logic heartbeat_en_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic mgmt_rd_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic media_tx_stb_o,
  input wire logic media_ed_pulse_o,
  input wire logic low_power_o,
  input wire logic mac_clk_o,
  input wire logic rx_dv_o,
  input wire logic crs_o,
  input wire logic crs_dv_o,
  input wire logic col_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  mii_no_crsdv_a: assert property (!strap_rmii_i |-> !crs_dv_o)
    else $error("crs_dv high without rmii strap");
  rmii_no_clk_a: assert property (crs_dv_o |-> !mac_clk_o)
    else $error("mii clock runs in rmii mode");
  // heartbeat excluded: its pulse is not a collision
  fdx_no_col_a: assert property (full_duplex_i && $past(full_duplex_i)
    && !heartbeat_en_i |-> !col_o) else $error("collision in full duplex");
  ed_pulse_lp_a: assert property (media_ed_pulse_o |-> low_power_o)
    else $error("energy pulse while awake");
  unmapped_zero_a: assert property (mgmt_rd_i && mgmt_addr_i != `EDC_OFFSET
    && mgmt_addr_i != `RIC_OFFSET |=> mgmt_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  edc_read_a: assert property (mgmt_rd_i && mgmt_addr_i == `EDC_OFFSET |=>
    mgmt_rdata_o[15:2] == 14'h0000 && mgmt_rdata_o[1] == $past(low_power_o))
    else $error("energy control read wrong");
  ric_read_a: assert property (mgmt_rd_i && mgmt_addr_i == `RIC_OFFSET |=>
    mgmt_rdata_o[15:6] == 10'h000 && (!mgmt_rdata_o[5] || strap_rmii_i))
    else $error("interface config read wrong");
  tx_stb_single_a: assert property (media_tx_stb_o |=> !media_tx_stb_o[*3])
    else $error("transmit strobe too long");
  // mii clock holds each level for at least five cycles after it changes
  mac_clk_hold_a: assert property ($changed(mac_clk_o) |=> $stable(mac_clk_o)[*4])
    else $error("mii clock toggles too fast");
  cover property ($rose(rx_dv_o));
  cover property ($rose(col_o));
  cover property ($rose(low_power_o));
  cover property ($rose(crs_dv_o));
endmodule

bind phy_mac_side phy_mac_side_asserts phy_mac_side_asserts_inst (.clk_sys_i, .resetn_i,
  .strap_rmii_i, .full_duplex_i, .heartbeat_en_i, .mgmt_addr_i, .mgmt_rd_i, .mgmt_rdata_o,
  .media_tx_stb_o, .media_ed_pulse_o, .low_power_o, .mac_clk_o, .rx_dv_o, .crs_o,
  .crs_dv_o, .col_o);

// ==== sim/phy_mac_side_tb.sv ====
// self-checking bench for the mac-side block
`timescale 1ns/1ps
`include "phy_mac_params.svh"
module phy_mac_side_tb;
  logic clk_sys_i = 1'h0, resetn_i = 1'h0, strap_rmii_i = 1'h0, link_ref_i = 1'h0;
  logic speed_100_i = 1'h1, full_duplex_i = 1'h1, heartbeat_en_i = 1'h0;
  logic [4:0] mgmt_addr_i = 5'h00;
  logic [15:0] mgmt_wdata_i = 16'h0000, mgmt_rdata_o;
  logic mgmt_wr_i = 1'h0, mgmt_rd_i = 1'h0, media_energy_i = 1'h1, media_squelch_ok_i = 1'h1;
  logic link_signal_present_i = 1'h1, media_rx_active_i = 1'h0, media_rx_bit_stb_i = 1'h0;
  logic media_rx_bit_i = 1'h0, media_rx_err_i = 1'h0, tx_en_i, media_tx_stb_o, media_tx_en_o;
  logic [3:0] txd_i, media_tx_data_o, rxd_o;
  logic media_ed_pulse_o, low_power_o, mac_clk_o, rx_dv_o, rx_er_o, crs_o, crs_dv_o, col_o;
  logic [3:0] txq[$];
  int error_cnt = 0, n_checks = 0;
  phy_mac_side #(.ED_IDLE_CYC(50), .ED_PERIOD_CYC(40), .ED_WAKE_CYC(20)) phy_mac_side_inst (
    .clk_sys_i, .resetn_i, .strap_rmii_i, .link_ref_i, .speed_100_i, .full_duplex_i,
    .heartbeat_en_i, .mgmt_addr_i, .mgmt_wdata_i, .mgmt_wr_i, .mgmt_rd_i, .mgmt_rdata_o,
    .media_energy_i, .media_squelch_ok_i, .link_signal_present_i, .media_rx_active_i,
    .media_rx_bit_stb_i, .media_rx_bit_i, .media_rx_err_i, .media_tx_stb_o, .media_tx_data_o,
    .media_tx_en_o, .media_ed_pulse_o, .low_power_o, .tx_en_i, .txd_i, .mac_clk_o, .rxd_o,
    .rx_dv_o, .rx_er_o, .crs_o, .crs_dv_o, .col_o);
  mac_model mac_model_inst (.mac_clk_i(mac_clk_o), .link_ref_i, .rmii_i(strap_rmii_i),
    .rx_dv_i(rx_dv_o), .rxd_i(rxd_o), .tx_en_o(tx_en_i), .txd_o(txd_i));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  // odd offset keeps reference edges off the system clock edges, at a fixed phase to them
  initial
  begin
    #37;
    forever #100 link_ref_i = ~link_ref_i;
  end
  always @(posedge clk_sys_i)
    if (media_tx_stb_o === 1'h1 && media_tx_en_o === 1'h1) txq.push_back(media_tx_data_o);
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    mgmt_addr_i = a;
    mgmt_wdata_i = d;
    mgmt_wr_i = 1'h1;
    @(negedge clk_sys_i);
    mgmt_wr_i = 1'h0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk_sys_i);
    mgmt_addr_i = a;
    mgmt_rd_i = 1'h1;
    @(negedge clk_sys_i);
    mgmt_rd_i = 1'h0;
    chk(mgmt_rdata_o, e);
  endtask
  // a wait that runs out is a mismatch and ends the run
  task automatic wait_sig(ref logic s, input logic v, input int n);
    for (int k = 0; k < n && s !== v; k++) @(negedge clk_sys_i);
    chk(16'(s), 16'(v));
    if (s !== v) tally_and_finish();
  endtask
  // one bit each four cycles matches the unit rate at 100M in both modes
  task automatic rx_frame(input int n, input int gap_at);
    media_rx_active_i = 1'h1;
    for (int i = 0; i < 4 * n; i++)
    begin
      repeat (3) @(negedge clk_sys_i);
      if (i == gap_at) repeat (200) @(negedge clk_sys_i);
      media_rx_bit_i = 1'((i / 4 * 3 + 1) >> (i % 4));
      media_rx_bit_stb_i = 1'h1;
      @(negedge clk_sys_i);
      media_rx_bit_stb_i = 1'h0;
    end
    media_rx_active_i = 1'h0;
    wait_sig(rx_dv_o, 1'h0, 300);
  endtask
  task automatic chk_rx(input int units, input int w);
    chk(16'(mac_model_inst.rxq.size()), 16'(units));
    foreach (mac_model_inst.rxq[k])
      chk(16'(mac_model_inst.rxq[k]), 16'(((k * w / 4 * 3 + 1) >> (k * w % 4)) & ((1 << w) - 1)));
    mac_model_inst.rxq.delete();
  endtask
  initial
  begin
    int t0;
    int hi;
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    rdchk(`EDC_OFFSET, 16'h0000);
    rdchk(`RIC_OFFSET, 16'h0001);
    for (int t = 0; t < 4; t++)
    begin
      wr(`RIC_OFFSET, 16'(t) | 16'h0020);
      rdchk(`RIC_OFFSET, 16'(t));
    end
    wr(5'h05, 16'hffff);
    rdchk(5'h05, 16'h0000);
    $display("registers done");
    fork
      rx_frame(8, -1);
      wait_sig(crs_o, 1'h1, 400);
    join
    wait_sig(crs_o, 1'h0, 50);
    chk_rx(8, 4);
    $display("mii receive done");
    full_duplex_i = 1'h0;
    fork
      rx_frame(8, -1);
      mac_model_inst.send(6);
      wait_sig(col_o, 1'h1, 300);
    join
    chk(16'(txq.size()), 16'h0006);
    foreach (txq[k]) chk(16'(txq[k]), 16'(k + 5));
    mac_model_inst.rxq.delete();
    $display("half duplex done");
    speed_100_i = 1'h0;
    heartbeat_en_i = 1'h1;
    fork
      mac_model_inst.send(2);
      begin
        wait_sig(crs_o, 1'h1, 900);
        media_rx_active_i = 1'h1;
        for (int b = 0; b < 7; b++)
        begin
          chk(16'(col_o), 16'h0000);
          media_rx_bit_stb_i = 1'h1;
          @(negedge clk_sys_i);
          media_rx_bit_stb_i = 1'h0;
          @(negedge clk_sys_i);
        end
        wait_sig(col_o, 1'h1, 4);
        media_rx_active_i = 1'h0;
      end
    join
    mac_model_inst.rxq.delete();
    t0 = 0;
    hi = 0;
    for (int c = 0; c < 150; c++)
    begin
      @(negedge clk_sys_i);
      if (col_o === 1'h1 && hi == 0) t0 = c;
      if (col_o === 1'h1) hi++;
    end
    chk(16'(hi), 16'(`SQE_LEN_CYC));
    chk(16'(t0 >= 40 && t0 <= 46), 16'h0001);
    heartbeat_en_i = 1'h0;
    speed_100_i = 1'h1;
    $display("heartbeat done");
    wr(`EDC_OFFSET, 16'h0001);
    media_energy_i = 1'h0;
    wait_sig(low_power_o, 1'h1, 100);
    rdchk(`EDC_OFFSET, 16'h0003);
    wait_sig(media_ed_pulse_o, 1'h1, 60);
    media_energy_i = 1'h1;
    wait_sig(low_power_o, 1'h0, 60);
    wr(`EDC_OFFSET, 16'h0000);
    $display("energy detect done");
    resetn_i = 1'h0;
    strap_rmii_i = 1'h1;
    full_duplex_i = 1'h1;
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    rdchk(`RIC_OFFSET, 16'h0021);
    fork
      rx_frame(8, -1);
      wait_sig(crs_dv_o, 1'h1, 200);
    join
    chk_rx(16, 2);
    fork
      rx_frame(8, 12);
      wait_sig(rx_er_o, 1'h1, 1000);
    join
    mac_model_inst.rxq.delete();
    rdchk(`RIC_OFFSET, 16'h0029);
    wr(`RIC_OFFSET, 16'h0029);
    rdchk(`RIC_OFFSET, 16'h0021);
    txq.delete();
    mac_model_inst.send_ref(4);
    chk(16'(txq.size()), 16'h0004);
    foreach (txq[k]) chk(16'(txq[k]), 16'((k + 1) & 3));
    $display("rmii done");
    tally_and_finish();
  end
  initial
  begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
endmodule

// ==== src/phy_mac_params.svh ====
// offsets, field positions, reset values and timing counts for the mac-side block
`ifndef PHY_MAC_PARAMS_SVH
`define PHY_MAC_PARAMS_SVH

`define EDC_OFFSET 5'h1d
`define RIC_OFFSET 5'h17
`define EDC_EN_BIT 0
`define EDC_LP_BIT 1
`define RIC_THR_LSB 0
`define RIC_OVR_BIT 2
`define RIC_UNR_BIT 3
`define RIC_RMII_BIT 5
`define RIC_THR_RESET 2'h1
`define EDC_EN_RESET 1'b0

`define CLK_MHZ 40
`define BIT10_NS 100
`define SQE_DELAY_NS 1000
`define SQE_LEN_BITS 10
`define SQE_DELAY_CYC ((`SQE_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define SQE_LEN_CYC ((`SQE_LEN_BITS * `BIT10_NS * `CLK_MHZ) / 1000)
`define ED_PULSE_NS 200
`define ED_PULSE_CYC ((`ED_PULSE_NS * `CLK_MHZ) / 1000)
`define COL_DELAY_BITS 3'h7
`define SLOW_DIV 10
`define CRS_ZEROS 2'h2

`endif

// ==== src/phy_mac_pkg.sv ====
// types shared by the mac-side block
package phy_mac_pkg;
  typedef enum logic [1:0] {ED_ACTIVE, ED_SLEEP, ED_WAKE} ed_state_e;
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] data;
  } rx_beat_s;
  typedef struct packed {
    logic rmii;
    logic unr;
    logic ovr;
    logic [1:0] thr;
  } ric_s;
endpackage

// ==== src/phy_mac_side.sv ====
// mac-facing side of a 10/100 transceiver: mii/rmii data, col, crs, energy detect
// What this block does
// [RL1] energy detect enabled and idle line: sleep; line activity wakes via power-up
// [RL2] while sleeping, periodically pulse transmitter with energy-detect pulses
// [RL3] mii or rmii chosen by strap or register; rmii only by strap
// [RL4] mii receive: 4-bit data, error and valid on receive clock
// [RL5] device supplies mii transmit clock; mac drives data and enable on it
// [RL6] half duplex: collision shown when transmit and receive both active
// [RL7] 10M collision while transmitting waits seven received bits, then holds
// [RL8] collision starting during receive is reported at once
// [RL9] 10M heartbeat: col pulse of ten bit times about 1us after packet
// [RL10] crs: squelch at 10M; link plus two non-contiguous zeros at 100M
// [RL11] crs from receive in full duplex, also transmit in half; drops at end
// [RL12] rmii moves two bits per reference clock each way
// [RL13] rmii: crs_dv, two-bit data, rx_er, separate rx_dv; accepts tx pins
// [RL14] rmii 10M: transmit sampled and receive updated every tenth clock
// [RL15] elasticity threshold 1,2,3,0 selects 4,8,12,16 bits in rmii; mii always starts at 4 bits
// [RL16] overrun or underrun corrupts frame and sets status flags
// [RL17] two 16-bit management registers, other addresses read zero, usable in both modes
// [RL18] rx_dv and first receive data change on the same edge
`timescale 1ns/1ps
`include "phy_mac_params.svh"
module phy_mac_side
  import phy_mac_pkg::*;
#(
  parameter int ED_IDLE_CYC = 40000,
  parameter int ED_PERIOD_CYC = 40000,
  parameter int ED_WAKE_CYC = 8000,
  parameter int EB_DEPTH = 32
)(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic strap_rmii_i,
  input wire logic link_ref_i,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic heartbeat_en_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  output logic [15:0] mgmt_rdata_o,
  input wire logic media_energy_i,
  input wire logic media_squelch_ok_i,
  input wire logic link_signal_present_i,
  input wire logic media_rx_active_i,
  input wire logic media_rx_bit_stb_i,
  input wire logic media_rx_bit_i,
  input wire logic media_rx_err_i,
  output logic media_tx_stb_o,
  output logic [3:0] media_tx_data_o,
  output logic media_tx_en_o,
  output logic media_ed_pulse_o,
  output logic low_power_o,
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic mac_clk_o,
  output logic [3:0] rxd_o,
  output logic rx_dv_o,
  output logic rx_er_o,
  output logic crs_o,
  output logic crs_dv_o,
  output logic col_o
);
  localparam int EBW = $clog2(EB_DEPTH);

  function automatic logic [4:0] thr_bits(input logic [1:0] thr);
    thr_bits = (thr == 2'h0) ? 5'h10 : {1'b0, thr, 2'h0};
  endfunction

  // pins from the mac and the reference clock are asynchronous
  logic strap_s;
  logic ref_s;
  logic tx_en_s;
  logic [3:0] txd_s;
  sync2 #(.W(7)) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i({strap_rmii_i, link_ref_i, tx_en_i, txd_i}),
    .q_o({strap_s, ref_s, tx_en_s, txd_s})
  );

  // strap capture and management registers
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic strap_rmii_reg, strap_rmii_next;
  logic edc_en_reg, edc_en_next;
  ric_s ric_reg, ric_next;
  logic [15:0] rdata_reg, rdata_next;
  logic ovr_ev, unr_ev;
  ed_state_e ed_reg, ed_next;

  always_comb
  begin
    strap_cnt_next = strap_cnt_reg;
    strap_rmii_next = strap_rmii_reg;
    ric_next = ric_reg;
    edc_en_next = edc_en_reg;
    rdata_next = rdata_reg;
    // synchroniser needs two edges after release before strap is valid
    if (strap_cnt_reg != 2'h3)
    begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2)
      begin
        strap_rmii_next = strap_s; // [RL3]
        ric_next.rmii = strap_s; // [RL3]
      end
    end
    if (mgmt_wr_i && mgmt_addr_i == `EDC_OFFSET)
      edc_en_next = mgmt_wdata_i[`EDC_EN_BIT]; // [RL1]
    if (mgmt_wr_i && mgmt_addr_i == `RIC_OFFSET)
    begin
      ric_next.thr = mgmt_wdata_i[`RIC_THR_LSB +: 2]; // [RL15]
      // software may leave rmii but never enter it without the strap
      ric_next.rmii = mgmt_wdata_i[`RIC_RMII_BIT] & strap_rmii_reg; // [RL3]
      if (mgmt_wdata_i[`RIC_OVR_BIT])
        ric_next.ovr = 1'b0;
      if (mgmt_wdata_i[`RIC_UNR_BIT])
        ric_next.unr = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (ovr_ev)
      ric_next.ovr = 1'b1; // [RL16]
    if (unr_ev)
      ric_next.unr = 1'b1; // [RL16]
    if (mgmt_rd_i)
    begin
      rdata_next = 16'h0000; // [RL17]
      if (mgmt_addr_i == `EDC_OFFSET)
      begin
        rdata_next[`EDC_EN_BIT] = edc_en_reg;
        rdata_next[`EDC_LP_BIT] = (ed_reg != ED_ACTIVE);
      end
      if (mgmt_addr_i == `RIC_OFFSET)
      begin
        rdata_next[`RIC_THR_LSB +: 2] = ric_reg.thr;
        rdata_next[`RIC_OVR_BIT] = ric_reg.ovr;
        rdata_next[`RIC_UNR_BIT] = ric_reg.unr;
        rdata_next[`RIC_RMII_BIT] = ric_reg.rmii;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      strap_cnt_reg <= 2'h0;
      strap_rmii_reg <= 1'b0;
      edc_en_reg <= `EDC_EN_RESET;
      ric_reg <= '{rmii: 1'b0, unr: 1'b0, ovr: 1'b0, thr: `RIC_THR_RESET};
      rdata_reg <= 16'h0000;
    end
    else
    begin
      strap_cnt_reg <= strap_cnt_next;
      strap_rmii_reg <= strap_rmii_next;
      edc_en_reg <= edc_en_next;
      ric_reg <= ric_next;
      rdata_reg <= rdata_next;
    end
  end

  // data slots from reference clock edges
  logic ref_q_reg, ref_q_next;
  logic [3:0] div_reg, div_next;
  logic mclk_reg, mclk_next;
  logic tick, wrap, tx_slot, rx_slot;

  always_comb
  begin
    ref_q_next = ref_s;
    tick = ref_s & ~ref_q_reg;
    div_next = div_reg;
    mclk_next = mclk_reg;
    wrap = 1'b0;
    if (tick)
    begin
      if (speed_100_i || div_reg == 4'(`SLOW_DIV - 1))
      begin
        div_next = 4'h0;
        wrap = 1'b1;
      end
      else
        div_next = div_reg + 4'h1;
    end
    if (wrap && !ric_reg.rmii)
      mclk_next = ~mclk_reg; // [RL5]
    // rmii: every slot moves both ways; 10M slows slots tenfold
    tx_slot = wrap && (ric_reg.rmii || !mclk_reg); // [RL14]
    rx_slot = wrap && (ric_reg.rmii || mclk_reg); // [RL14]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ref_q_reg <= 1'b0;
      div_reg <= 4'h0;
      mclk_reg <= 1'b0;
    end
    else
    begin
      ref_q_reg <= ref_q_next;
      div_reg <= div_next;
      mclk_reg <= mclk_next;
    end
  end

  assign mac_clk_o = mclk_reg & ~ric_reg.rmii; // [RL4]

  // transmit capture
  logic tx_stb_reg, tx_stb_next;
  logic [3:0] tx_data_reg, tx_data_next;
  logic tx_on_reg, tx_on_next;

  always_comb
  begin
    tx_stb_next = tx_slot;
    tx_data_next = tx_data_reg;
    tx_on_next = tx_on_reg;
    if (tx_slot)
    begin
      tx_data_next = ric_reg.rmii ? {2'h0, txd_s[1:0]} : txd_s; // [RL12]
      tx_on_next = tx_en_s; // [RL13]
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      tx_stb_reg <= 1'b0;
      tx_data_reg <= 4'h0;
      tx_on_reg <= 1'b0;
    end
    else
    begin
      tx_stb_reg <= tx_stb_next;
      tx_data_reg <= tx_data_next;
      tx_on_reg <= tx_on_next;
    end
  end

  // collision, heartbeat and carrier sense
  logic tx_first_reg, tx_first_next;
  logic tx_q_reg, tx_q_next;
  logic [2:0] col_bits_reg, col_bits_next;
  logic [7:0] sqe_reg, sqe_next;
  logic [1:0] zeros_reg, zeros_next;
  logic prev_bit_reg, prev_bit_next;
  logic col_reg, col_next;
  logic crs_reg, crs_next;
  logic rx_crs_reg, rx_crs_next;
  logic col_raw;

  always_comb
  begin
    tx_q_next = tx_en_s;
    col_raw = !full_duplex_i && tx_en_s && media_rx_active_i; // [RL6]
    tx_first_next = tx_first_reg;
    if (!tx_en_s)
      tx_first_next = 1'b0;
    else if (!tx_q_reg && !media_rx_active_i)
      tx_first_next = 1'b1;
    col_bits_next = col_bits_reg;
    if (!col_raw)
      col_bits_next = 3'h0;
    else if (media_rx_bit_stb_i && col_bits_reg != `COL_DELAY_BITS)
      col_bits_next = col_bits_reg + 3'h1; // [RL7]
    sqe_next = sqe_reg;
    if (tx_q_reg && !tx_en_s && heartbeat_en_i && !speed_100_i)
      sqe_next = 8'(`SQE_DELAY_CYC + `SQE_LEN_CYC); // [RL9]
    else if (sqe_reg != 8'h00)
      sqe_next = sqe_reg - 8'h01;
    col_next = (col_raw && (speed_100_i || !tx_first_reg // [RL8]
                || col_bits_reg == `COL_DELAY_BITS)) // [RL7]
               || (sqe_reg != 8'h00 && sqe_reg <= 8'(`SQE_LEN_CYC)); // [RL9]
    // idle 100M line is ones, so the first zero counts as non-contiguous
    zeros_next = zeros_reg;
    prev_bit_next = prev_bit_reg;
    if (!media_rx_active_i)
    begin
      zeros_next = 2'h0;
      prev_bit_next = 1'b1;
    end
    else if (media_rx_bit_stb_i)
    begin
      prev_bit_next = media_rx_bit_i;
      if (!media_rx_bit_i && prev_bit_reg && zeros_reg != `CRS_ZEROS)
        zeros_next = zeros_reg + 2'h1; // [RL10]
    end
    rx_crs_next = media_rx_active_i && (speed_100_i
                  ? (link_signal_present_i && zeros_reg == `CRS_ZEROS) // [RL10]
                  : media_squelch_ok_i); // [RL10]
    crs_next = rx_crs_reg || (!full_duplex_i && tx_en_s); // [RL11]
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      tx_first_reg <= 1'b0;
      tx_q_reg <= 1'b0;
      col_bits_reg <= 3'h0;
      sqe_reg <= 8'h00;
      zeros_reg <= 2'h0;
      prev_bit_reg <= 1'b1;
      col_reg <= 1'b0;
      crs_reg <= 1'b0;
      rx_crs_reg <= 1'b0;
    end
    else
    begin
      tx_first_reg <= tx_first_next;
      tx_q_reg <= tx_q_next;
      col_bits_reg <= col_bits_next;
      sqe_reg <= sqe_next;
      zeros_reg <= zeros_next;
      prev_bit_reg <= prev_bit_next;
      col_reg <= col_next;
      crs_reg <= crs_next;
      rx_crs_reg <= rx_crs_next;
    end
  end

  // energy detect power state
  logic [15:0] ed_cnt_reg, ed_cnt_next;

  always_comb
  begin
    ed_next = ed_reg;
    ed_cnt_next = ed_cnt_reg + 16'h0001;
    unique case (ed_reg)
      ED_ACTIVE:
      begin
        if (!edc_en_reg || media_energy_i)
          ed_cnt_next = 16'h0000;
        else if (ed_cnt_reg == 16'(ED_IDLE_CYC - 1))
        begin
          ed_next = ED_SLEEP; // [RL1]
          ed_cnt_next = 16'h0000;
        end
      end
      ED_SLEEP:
      begin
        if (media_energy_i || !edc_en_reg)
        begin
          ed_next = ED_WAKE; // [RL1]
          ed_cnt_next = 16'h0000;
        end
        else if (ed_cnt_reg == 16'(ED_PERIOD_CYC - 1))
          ed_cnt_next = 16'h0000; // [RL2]
      end
      ED_WAKE:
      begin
        if (ed_cnt_reg == 16'(ED_WAKE_CYC - 1))
        begin
          ed_next = ED_ACTIVE; // [RL1]
          ed_cnt_next = 16'h0000;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ed_reg <= ED_ACTIVE;
      ed_cnt_reg <= 16'h0000;
    end
    else
    begin
      ed_reg <= ed_next;
      ed_cnt_reg <= ed_cnt_next;
    end
  end

  // pulses fire regardless of energy seen; the wake path is separate
  assign media_ed_pulse_o = (ed_reg == ED_SLEEP) && (ed_cnt_reg < 16'(`ED_PULSE_CYC)); // [RL2]
  assign low_power_o = (ed_reg != ED_ACTIVE);

  // receive path through the elasticity buffer
  logic [EBW:0] eb_level;
  logic [3:0] eb_data;
  logic eb_rd, eb_flush, need_ok;
  logic run_reg, run_next;
  logic err_reg, err_next;
  rx_beat_s rx_reg, rx_next;

  always_comb
  begin
    need_ok = eb_level >= (ric_reg.rmii ? (EBW+1)'(2) : (EBW+1)'(4));
    run_next = run_reg;
    err_next = err_reg || ovr_ev || unr_ev || (media_rx_err_i && media_rx_active_i);
    rx_next = rx_reg;
    eb_rd = 1'b0;
    eb_flush = 1'b0;
    if (rx_slot)
    begin
      if (!run_reg)
      begin
        rx_next = '0;
        // mii needs only one nibble; rmii waits for the programmed fill
        if (media_rx_active_i && eb_level >= (ric_reg.rmii
            ? (EBW+1)'(thr_bits(ric_reg.thr)) : (EBW+1)'(4))) // [RL15]
        begin
          run_next = 1'b1;
          eb_rd = 1'b1;
        end
        else if (!media_rx_active_i)
        begin
          eb_flush = 1'b1;
          err_next = 1'b0;
        end
      end
      else if (need_ok || media_rx_active_i)
        eb_rd = 1'b1; // [RL16]
      else
      begin
        run_next = 1'b0;
        rx_next = '0;
        eb_flush = 1'b1;
        err_next = 1'b0;
      end
      if (eb_rd)
      begin
        rx_next.dv = 1'b1; // [RL18]
        rx_next.er = err_next; // [RL16]
        // inverted bits guarantee a bad frame check once the frame is hurt
        rx_next.data = (ric_reg.rmii ? {2'h0, eb_data[1:0]} : eb_data) // [RL12]
                       ^ {4{err_next}}; // [RL16]
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      run_reg <= 1'b0;
      err_reg <= 1'b0;
      rx_reg <= '0;
    end
    else
    begin
      run_reg <= run_next;
      err_reg <= err_next;
      rx_reg <= rx_next;
    end
  end

  rx_elastic_buf #(.DEPTH(EB_DEPTH)) u_ebuf (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .flush_i(eb_flush),
    .wr_i(media_rx_bit_stb_i && media_rx_active_i && !low_power_o),
    .wr_bit_i(media_rx_bit_i),
    .rd_i(eb_rd),
    .rd_four_i(!ric_reg.rmii),
    .level_o(eb_level),
    .rd_data_o(eb_data),
    .ovr_o(ovr_ev),
    .unr_o(unr_ev)
  );

  assign rxd_o = rx_reg.data; // [RL4]
  assign rx_dv_o = rx_reg.dv; // [RL13]
  assign rx_er_o = rx_reg.er;
  assign crs_dv_o = ric_reg.rmii && (rx_crs_reg || rx_reg.dv); // [RL13]
  assign crs_o = crs_reg;
  assign col_o = col_reg;
  assign media_tx_stb_o = tx_stb_reg;
  assign media_tx_data_o = tx_data_reg;
  assign media_tx_en_o = tx_on_reg;
  assign mgmt_rdata_o = rdata_reg;
endmodule

// ==== src/rx_elastic_buf.sv ====
// bit-wide receive elasticity buffer, read two or four bits at a time
`timescale 1ns/1ps
module rx_elastic_buf #(
  parameter int DEPTH = 32
)(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  input wire logic wr_i,
  input wire logic wr_bit_i,
  input wire logic rd_i,
  input wire logic rd_four_i,
  output logic [$clog2(DEPTH):0] level_o,
  output logic [3:0] rd_data_o,
  output logic ovr_o,
  output logic unr_o
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0] mem;
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] wptr_next;
  logic [AW-1:0] rptr_reg;
  logic [AW-1:0] rptr_next;
  logic [AW:0] level_reg;
  logic [AW:0] level_next;
  logic [AW:0] rd_n;
  logic do_wr;
  logic do_rd;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_rd
      assign rd_data_o[i] = mem[rptr_reg + AW'(i)];
    end
  endgenerate

  always_comb
  begin
    rd_n = rd_four_i ? (AW+1)'(4) : (AW+1)'(2);
    // full buffer drops the bit; the frame is then marked bad upstream
    ovr_o = wr_i && (level_reg == (AW+1)'(DEPTH));
    do_wr = wr_i && !ovr_o;
    unr_o = rd_i && (level_reg < rd_n);
    do_rd = rd_i && !unr_o;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    level_next = level_reg;
    if (flush_i)
    begin
      rptr_next = wptr_reg;
      level_next = '0;
    end
    else
    begin
      if (do_wr)
        wptr_next = wptr_reg + 1'b1;
      if (do_rd)
        rptr_next = rptr_reg + rd_n[AW-1:0];
      level_next = level_reg + (do_wr ? (AW+1)'(1) : '0) - (do_rd ? rd_n : '0);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      level_reg <= level_next;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (do_wr && !flush_i)
      mem[wptr_reg] <= wr_bit_i;
  end

  assign level_o = level_reg;
endmodule

// ==== src/sync2.sv ====
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
)(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb
  begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule
